// ===== rtl/nvmi2c_consts.svh
`ifndef NVMI2C_CONSTS_SVH
`define NVMI2C_CONSTS_SVH

// Array geometry.
`define NVMI2C_DATA_W      8
`define NVMI2C_ADDR_W      13
`define NVMI2C_DEPTH       8192
`define NVMI2C_HI_USED     5

// Serial framing.
`define NVMI2C_BITS        4'h8
`define NVMI2C_CNT_RST     4'h0

// Cycles after reset before pin edges are trusted.
`define NVMI2C_SETTLE_RST  2'h0
`define NVMI2C_SETTLE_END  2'h3

// Field positions inside the device address word.
`define NVMI2C_TYPE_MSB    7
`define NVMI2C_TYPE_LSB    4
`define NVMI2C_SEL_MSB     3
`define NVMI2C_SEL_LSB     1
`define NVMI2C_RW_BIT      0

// Reset values.
`define NVMI2C_ADDR_RST    13'h0000
`define NVMI2C_HI_RST      5'h00
`define NVMI2C_BYTE_RST    8'h00

`endif

// ===== rtl/nvmi2c_pkg.sv
`default_nettype none
package nvmi2c_pkg;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_RECV = 5'h02,
      ST_ACK  = 5'h04,
      ST_SEND = 5'h08,
      ST_MACK = 5'h10
   } nvmi2c_state_e;

   typedef enum logic [3:0] {
      PH_DEV  = 4'h1,
      PH_AHI  = 4'h2,
      PH_ALO  = 4'h4,
      PH_DATA = 4'h8
   } nvmi2c_phase_e;

   typedef struct packed {
      logic       scl;
      logic       sda;
      logic       wp;
      logic [2:0] sel;
   } nvmi2c_pins_s;

   typedef struct packed {
      logic        we;
      logic [12:0] waddr;
      logic [7:0]  wdata;
   } nvmi2c_wr_s;

endpackage
`default_nettype wire

// ===== rtl/nvmi2c_sync.sv
`default_nettype none
module nvmi2c_sync #(
   parameter int W = 6
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Asynchronous levels in, clocked levels out
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   logic [W-1:0] stage1;

   // Each bit gets its own pair so no logic ever looks at the first stage.
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               stage1[i] <= 1'b0;
               dout[i]   <= 1'b0;
            end else begin
               stage1[i] <= din[i];
               dout[i]   <= stage1[i];
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// ===== rtl/nvmi2c_mem.sv
`default_nettype none
`include "nvmi2c_consts.svh"
module nvmi2c_mem
   import nvmi2c_pkg::*;
(
   // Clock
   input  wire logic                       clk,
   // Write side
   input  wire nvmi2c_wr_s                 wr,
   // Read side
   input  wire logic [`NVMI2C_ADDR_W-1:0]  raddr,
   output logic      [`NVMI2C_DATA_W-1:0]  rdata
);

   logic [`NVMI2C_DATA_W-1:0] cells [0:`NVMI2C_DEPTH-1];

   // No reset on the array so it maps onto block memory.
   always_ff @(posedge clk) begin
      if (wr.we) begin
         cells[wr.waddr] <= wr.wdata;
      end
   end

   always_ff @(posedge clk) begin
      rdata <= cells[raddr];
   end

endmodule
`default_nettype wire

// ===== rtl/nvmi2c_slave.sv
// Behaviour
// - sample on SCL rise, drive on fall
// - SDA falling with SCL high starts
// - stop ends transfer, return to standby
// - receiver pulls SDA low on ninth clock
// - transmitter releases SDA during acknowledge clock
// - stop before acknowledge aborts to standby
// - release bus after not-acknowledge
// - first byte is type, select, direction
// - upper four bits match device type
// - select code must equal strap pins
// - eighth bit chooses write or read
// - mismatch means no response, stay standby
// - open select pins read low
// - protect pin high blocks array writes
// - reads work whatever protect level
// - open protect pin reads low
// - ready at once after write stop
// - data line driven low only
// - array holds 8192 bytes
// - two address bytes, high first, acknowledged
// - address increments and wraps to zero
// - addressless read continues after last access
`default_nettype none
`include "nvmi2c_consts.svh"
module nvmi2c_slave
   import nvmi2c_pkg::*;
#(
   // Device type code; this value is arbitrary.
   parameter logic [3:0] DEV_TYPE = 4'h5
) (
   // Clock and reset
   input  wire logic       CLK,
   input  wire logic       RESETN,
   // Serial bus
   input  wire logic       SCL,
   input  wire logic       SDA_IN,
   output logic            SDA_OUT,
   output logic            SDA_OE,
   // Straps
   input  wire logic       WP,
   input  wire logic [2:0] DEVICE_SELECT_PINS
);

   logic                       rst_meta;
   logic                       rst_n;
   nvmi2c_pins_s               pins_raw;
   nvmi2c_pins_s               pins;
   logic                       scl_prev;
   logic                       sda_prev;
   logic [1:0]                 settle;
   logic                       settled;
   logic                       scl_rise;
   logic                       scl_fall;
   logic                       start_det;
   logic                       stop_det;
   nvmi2c_state_e              state;
   nvmi2c_state_e              next_state;
   nvmi2c_phase_e              phase;
   logic [3:0]                 bit_cnt;
   logic                       byte_done;
   logic [`NVMI2C_DATA_W-1:0]  rx;
   logic [`NVMI2C_DATA_W-1:0]  tx;
   logic [`NVMI2C_DATA_W-1:0]  next_tx;
   logic                       dev_match;
   logic                       enter_ack;
   logic                       leave_ack;
   logic                       sent_byte;
   logic [`NVMI2C_HI_USED-1:0] addr_hi;
   logic [`NVMI2C_ADDR_W-1:0]  addr;
   logic [`NVMI2C_DATA_W-1:0]  rdata;
   nvmi2c_wr_s                 wr;
   logic                       sda_oe;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // The pads carry pull-downs, so open straps arrive here as low.
   always_comb begin
      pins_raw.scl = SCL;
      pins_raw.sda = SDA_IN;
      pins_raw.wp  = WP;
      pins_raw.sel = DEVICE_SELECT_PINS;
   end

   nvmi2c_sync #(
      .W($bits(nvmi2c_pins_s))
   ) u_sync (
      .clk  (CLK),
      .rst_n(rst_n),
      .din  (pins_raw),
      .dout (pins)
   );

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         scl_prev <= 1'b0;
         sda_prev <= 1'b1;
      end else begin
         scl_prev <= pins.scl;
         sda_prev <= pins.sda;
      end
   end

   // The synchronisers leave reset low, not at the idle bus level, so edges are ignored
   // until both stages and the previous-value flops hold real pin levels.
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         settle <= `NVMI2C_SETTLE_RST;
      end else if (settle != `NVMI2C_SETTLE_END) begin
         settle <= settle + 2'h1;
      end
   end

   // A master that starts within a few cycles of reset is not seen, which is accepted.
   assign settled = (settle == `NVMI2C_SETTLE_END);

   // Edges are found on the synchronised copies, so SCL and SDA keep their relative order.
   assign scl_rise  = settled & pins.scl & ~scl_prev;
   assign scl_fall  = settled & ~pins.scl & scl_prev;
   assign start_det = settled & pins.scl & scl_prev & sda_prev & ~pins.sda;
   assign stop_det  = settled & pins.scl & scl_prev & ~sda_prev & pins.sda;

   assign byte_done = (bit_cnt == `NVMI2C_BITS);
   assign dev_match = (rx[`NVMI2C_TYPE_MSB:`NVMI2C_TYPE_LSB] == DEV_TYPE)
                      && (rx[`NVMI2C_SEL_MSB:`NVMI2C_SEL_LSB] == pins.sel);

   always_comb begin
      next_state = state;
      if (stop_det) begin
         next_state = ST_IDLE;
      end else if (start_det) begin
         next_state = ST_RECV;
      end else begin
         case (state)
            ST_IDLE: begin
               next_state = ST_IDLE;
            end
            ST_RECV: begin
               if (scl_fall && byte_done) begin
                  if (phase == PH_DEV && !dev_match) begin
                     next_state = ST_IDLE;
                  end else begin
                     next_state = ST_ACK;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  if (phase == PH_DEV && rx[`NVMI2C_RW_BIT]) begin
                     next_state = ST_SEND;
                  end else begin
                     next_state = ST_RECV;
                  end
               end
            end
            ST_SEND: begin
               if (scl_fall && byte_done) begin
                  next_state = ST_MACK;
               end
            end
            ST_MACK: begin
               if (scl_rise && pins.sda) begin
                  next_state = ST_IDLE;
               end else if (scl_fall) begin
                  next_state = ST_SEND;
               end
            end
            default: begin
               next_state = ST_IDLE;
            end
         endcase
      end
   end

   assign enter_ack = (state == ST_RECV) && (next_state == ST_ACK);
   assign leave_ack = (state == ST_ACK) && scl_fall && !stop_det && !start_det;
   assign sent_byte = (state == ST_SEND) && (next_state == ST_MACK);

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         phase <= PH_DEV;
      end else if (start_det) begin
         phase <= PH_DEV;
      end else if (leave_ack) begin
         case (phase)
            PH_DEV:  phase <= PH_AHI;
            PH_AHI:  phase <= PH_ALO;
            PH_ALO:  phase <= PH_DATA;
            PH_DATA: phase <= PH_DATA;
            default: phase <= PH_DEV;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt <= `NVMI2C_CNT_RST;
      end else if (start_det || (state != next_state)) begin
         bit_cnt <= `NVMI2C_CNT_RST;
      end else if (scl_rise && (state == ST_RECV || state == ST_SEND) && !byte_done) begin
         bit_cnt <= bit_cnt + 4'h1;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         rx <= `NVMI2C_BYTE_RST;
      end else if (scl_rise && state == ST_RECV && !byte_done) begin
         rx <= {rx[`NVMI2C_DATA_W-2:0], pins.sda};
      end
   end

   always_comb begin
      next_tx = tx;
      if (next_state == ST_SEND && state != ST_SEND) begin
         next_tx = rdata;
      end else if (state == ST_SEND && scl_fall) begin
         next_tx = {tx[`NVMI2C_DATA_W-2:0], 1'b0};
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         tx <= `NVMI2C_BYTE_RST;
      end else begin
         tx <= next_tx;
      end
   end

   // Drive changes with state moves and SEND bit shifts, all at SCL fall or at start and stop; only MACK to IDLE moves at SCL rise.
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         sda_oe <= 1'b0;
      end else begin
         sda_oe <= (next_state == ST_ACK)
                   || (next_state == ST_SEND && !next_tx[`NVMI2C_DATA_W-1]);
      end
   end

   assign SDA_OUT = 1'b0;
   assign SDA_OE  = sda_oe;

   // The top three bits of the high byte are dropped, which keeps the address inside the array.
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         addr_hi <= `NVMI2C_HI_RST;
      end else if (enter_ack && phase == PH_AHI) begin
         addr_hi <= rx[`NVMI2C_HI_USED-1:0];
      end
   end

   // The counter survives stop, so an addressless read picks up where the last access ended.
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         addr <= `NVMI2C_ADDR_RST;
      end else if (enter_ack && phase == PH_ALO) begin
         addr <= {addr_hi, rx};
      end else if ((enter_ack && phase == PH_DATA) || sent_byte) begin
         addr <= addr + 13'h0001;
      end
   end

   // A protected byte is still acknowledged; only the store is suppressed.
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         wr.we    <= 1'b0;
         wr.waddr <= `NVMI2C_ADDR_RST;
         wr.wdata <= `NVMI2C_BYTE_RST;
      end else begin
         wr.we    <= enter_ack && (phase == PH_DATA) && !pins.wp;
         wr.waddr <= addr;
         wr.wdata <= rx;
      end
   end

   nvmi2c_mem u_mem (
      .clk  (CLK),
      .wr   (wr),
      .raddr(addr),
      .rdata(rdata)
   );

endmodule
`default_nettype wire

// ===== tb/nvmi2c_slave_asserts.sv
`default_nettype none
module nvmi2c_asserts (
   // Clock and reset
   input wire logic       CLK,
   input wire logic       RESETN,
   // Serial bus
   input wire logic       SCL,
   input wire logic       SDA_IN,
   input wire logic       SDA_OUT,
   input wire logic       SDA_OE,
   // Straps
   input wire logic       WP,
   input wire logic [2:0] DEVICE_SELECT_PINS
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   logic       scl_q;
   logic       sda_q;
   logic [3:0] lo_cnt;
   logic [3:0] cond_cnt;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= SCL;
         sda_q <= SDA_IN;
      end
   end
   // Cycles of SCL low; the device may only move its drive a few cycles after the fall.
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) lo_cnt <= 4'hF;
      else if (SCL) lo_cnt <= 4'h0;
      else if (lo_cnt != 4'hF) lo_cnt <= lo_cnt + 4'h1;
   end
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) cond_cnt <= 4'hF;
      else if (SCL && scl_q && SDA_IN != sda_q) cond_cnt <= 4'h0;
      else if (cond_cnt != 4'hF) cond_cnt <= cond_cnt + 4'h1;
   end
   sequence s_stop;
      SCL && scl_q && SDA_IN && !sda_q;
   endsequence
   chk_out_low: assert property (!SDA_OUT)
      else $error("data output not low");
   chk_rise_window: assert property ($rose(SDA_OE) |-> lo_cnt inside {[2:6]})
      else $error("drive began outside SCL low window");
   chk_fall_window: assert property ($fell(SDA_OE) |-> lo_cnt inside {[2:6]} || cond_cnt < 4'h8)
      else $error("drive released at wrong moment");
   chk_high_stable: assert property ($rose(SCL) |=> $stable(SDA_OE)[*4])
      else $error("drive moved while SCL high");
   chk_ack_hold: assert property ($rose(SDA_OE) |-> SDA_OE[*8])
      else $error("drive too short");
   chk_stop_idle: assert property (s_stop |=> (!SDA_OE)[*8])
      else $error("drive after stop");
   chk_reset_idle: assert property ($rose(RESETN) |-> (!SDA_OE)[*4])
      else $error("drive after reset");
   chk_move_scl_low: assert property ($rose(SDA_OE) || $fell(SDA_OE) |-> !SCL && !scl_q)
      else $error("drive moved outside SCL low");
endmodule
bind nvmi2c_slave nvmi2c_asserts i_nvmi2c_asserts (
   .CLK(CLK), .RESETN(RESETN), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
   .SDA_OE(SDA_OE), .WP(WP), .DEVICE_SELECT_PINS(DEVICE_SELECT_PINS)
);
`default_nettype wire

// ===== tb/nvmi2c_master.sv
`default_nettype none
module nvmi2c_master (
   // Clock and wire level
   input  wire logic clk,
   input  wire logic sda,
   // Master drives
   output logic      scl,
   output logic      sda_m
);
   timeunit 1ns;
   timeprecision 1ps;
   // Quarter bit in clock cycles; raise it for a slow master.
   int q = 8;
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   task automatic tick();
      repeat (q) @(negedge clk);
   endtask
   // Also serves as repeated start, entered with SCL low.
   task automatic start();
      sda_m = 1'b1;
      tick();
      scl = 1'b1;
      tick();
      sda_m = 1'b0;
      tick();
      scl = 1'b0;
      tick();
   endtask
   task automatic stop();
      sda_m = 1'b0;
      tick();
      scl = 1'b1;
      tick();
      sda_m = 1'b1;
      tick();
   endtask
   task automatic bitx(input logic b, output logic r);
      sda_m = b;
      tick();
      scl = 1'b1;
      tick();
      r = sda;
      tick();
      scl = 1'b0;
      tick();
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], r);
      bitx(1'b1, r);
      ack = !r;
   endtask
   task automatic rbyte(input logic a, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
      bitx(!a, r);
   endtask
endmodule
`default_nettype wire

// ===== tb/tb_nvmi2c_slave.sv
`default_nettype none
module tb_nvmi2c_slave;
   timeunit 1ns;
   timeprecision 1ps;
   // Device type code; this value is arbitrary.
   localparam logic [3:0] DEVT = 4'h6;
   logic        CLK;
   logic        RESETN;
   logic        WP;
   logic [2:0]  sel;
   wire logic   SCL;
   wire logic   sda_m;
   wire logic   SDA_IN;
   wire logic   SDA_OUT;
   wire logic   SDA_OE;
   logic [7:0]  d [4];
   logic [7:0]  r;
   logic [12:0] a;
   logic        ack;
   int          seed = 32'h61295fd0;
   int          err_total;
   int          check_count;
   int          cyc;
   // Open-drain wire with pull-up.
   assign SDA_IN = sda_m & !SDA_OE;
   nvmi2c_slave #(.DEV_TYPE(DEVT)) i_nvmi2c_slave (
      .CLK(CLK), .RESETN(RESETN), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
      .SDA_OE(SDA_OE), .WP(WP), .DEVICE_SELECT_PINS(sel));
   nvmi2c_master i_nvmi2c_master (.clk(CLK), .sda(SDA_IN), .scl(SCL), .sda_m(sda_m));
   initial begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end
   function automatic logic [7:0] dw(input logic rw);
      return {DEVT, sel, rw};
   endfunction
   task automatic results();
      $display("checks %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         $display("unexpected cycles: expected below 40000, seen %0d", cyc);
         results();
      end
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      check_count++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", n, e, s);
      end
   endtask
   task automatic ck(input string n);
      chk(n, 8'h01, {7'h00, ack});
   endtask
   task automatic setaddr(input logic [12:0] x);
      i_nvmi2c_master.start();
      i_nvmi2c_master.wbyte(dw(1'b0), ack);
      ck("write word ack");
      i_nvmi2c_master.wbyte({3'h0, x[12:8]}, ack);
      ck("high address ack");
      i_nvmi2c_master.wbyte(x[7:0], ack);
      ck("low address ack");
   endtask
   // Optional address phase, then n bytes; the master refuses the last one.
   task automatic rd(input logic ad, input logic [12:0] x, input int n, input int o);
      if (ad) setaddr(x);
      i_nvmi2c_master.start();
      i_nvmi2c_master.wbyte(dw(1'b1), ack);
      ck("read word ack");
      for (int i = 0; i < n; i++) begin
         i_nvmi2c_master.rbyte(i < n - 1, r);
         chk("read data", d[o + i], r);
      end
      i_nvmi2c_master.stop();
   endtask
   initial begin
      RESETN = 1'b0;
      WP = 1'b0;
      sel = 3'($random(seed));
      repeat (3) @(negedge CLK);
      RESETN = 1'b1;
      repeat (6) @(negedge CLK);
      foreach (d[i]) d[i] = 8'($random(seed));
      // Burst over the top of the array, so the address wraps to zero.
      a = 13'h1FFE;
      setaddr(a);
      for (int i = 0; i < 4; i++) begin
         i_nvmi2c_master.wbyte(d[i], ack);
         ck("data ack");
      end
      i_nvmi2c_master.stop();
      $display("write burst done");
      rd(1'b1, a, 3, 0);
      rd(1'b0, a, 1, 3);
      $display("read back done");
      WP = 1'b1;
      setaddr(a);
      i_nvmi2c_master.wbyte(~d[0], ack);
      ck("protected data ack");
      i_nvmi2c_master.stop();
      rd(1'b1, a, 1, 0);
      WP = 1'b0;
      $display("protect done");
      // One select bit or the type code wrong in each word.
      for (int k = 0; k < 4; k++) begin
         i_nvmi2c_master.start();
         i_nvmi2c_master.wbyte(dw(1'b0) ^ (8'h02 << k), ack);
         chk("foreign word ack", 8'h00, {7'h00, ack});
         i_nvmi2c_master.stop();
      end
      $display("foreign words done");
      // A stop on the eighth bit, before its clock falls, must leave the array untouched.
      setaddr(a);
      for (int i = 0; i < 7; i++) i_nvmi2c_master.bitx(~d[0][7 - i], ack);
      i_nvmi2c_master.stop();
      rd(1'b1, a, 1, 0);
      $display("abort done");
      results();
   end
endmodule
`default_nettype wire
